// File: hdl/camera_io_pwm_trigger_logic.sv
// Summary of operation
// - Modulator frequency is fixed within an interval; period and duty are both set per interval.
// - Period equals programmed count times one 15 ns clock.
// - Four lines, each with own duty setting per interval.
// - Combiner takes exactly two inputs, yields one result.
// - Result routes to trigger, next combiner stage or output line.
// - AND: high only when both inputs high.
// - NAND: low only when both inputs high.
// - OR: low only when both inputs low.
// - NOR high only for 00; inverted NOR low only for 00.
// - Debouncer passes a change only after it holds for hold time.
// - Hold time counted in 15 ns clock cycles.
// - Debouncer is optional, enabled between input and trigger.
// - Prescaler forwards one pulse per divisor pulses, divisor 1..16.
// - Up to 16 intervals, each with own settings, run in turn.
`timescale 1ns/1ps
`default_nettype none
module camera_io_pwm_trigger_logic
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [2:0] trigger_in,
   output logic trigger_out,
   output logic [3:0] pwm_line,
   output logic [3:0] pwm_line_oe,
   output logic logic_out,
   output logic logic_out_oe
);
   logic [23:0] pwm_period_count [0:15];
   logic [27:0] pwm_line_duty_percent [0:15];
   logic [3:0] sequence_interval_index;
   logic [3:0] seq_last;
   logic [23:0] debounce_hold_count;
   logic [3:0] prescale_div;
   logic deb_en;
   camera_io_pkg::logic_cfg_t cfg;
   camera_io_pkg::seq_state_t seq_state;
   logic [3:0] pwm_raw;
   logic period_end;
   logic [23:0] hold_cnt;
   logic deb_level;
   logic src_d;
   logic stage_a;
   logic stage_b;
   logic trig_src;
   logic trig_prev;
   logic trig_edge;
   logic [3:0] pre_cnt;
   logic seq_start;

   // ==========================================================
   // Combiner function
   function automatic logic combine(input logic [2:0] op, input logic a, input logic b);
      case (op)
         camera_io_pkg::OP_AND: combine = a & b;
         camera_io_pkg::OP_NAND: combine = ~(a & b);
         camera_io_pkg::OP_OR: combine = a | b;
         camera_io_pkg::OP_NOR: combine = ~(a | b);
         camera_io_pkg::OP_NOR_INV: combine = a | b;
         default: combine = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // Register writes
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         deb_en <= 1'b0;
         cfg <= '0;
         debounce_hold_count <= camera_io_pkg::HOLD_RESET;
         prescale_div <= camera_io_pkg::PRESCALE_RESET;
         seq_last <= 4'h0;
      end
      else if (wr)
      begin
         case (addr)
            camera_io_pkg::ADDR_CONTROL: deb_en <= wdata[camera_io_pkg::CTRL_DEB_EN];
            camera_io_pkg::ADDR_LOGIC_CFG: cfg <= wdata[7:0];
            camera_io_pkg::ADDR_HOLD: debounce_hold_count <= wdata[23:0];
            camera_io_pkg::ADDR_PRESCALE: prescale_div <= wdata[3:0];
            camera_io_pkg::ADDR_SEQ_COUNT: seq_last <= wdata[3:0];
            default: seq_last <= seq_last;
         endcase
      end
   end

   // Interval tables: period at 0x40+4n, four 7-bit duties at 0x80+4n
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         for (int i = 0; i < camera_io_pkg::NUM_INTERVALS; i++)
         begin
            pwm_period_count[i] <= camera_io_pkg::PERIOD_RESET;
            pwm_line_duty_percent[i] <= '0;
         end
      end
      else if (wr && addr[7:6] == camera_io_pkg::ADDR_PERIOD_BASE[7:6])
      begin
         pwm_period_count[addr[5:2]] <= (wdata[23:0] < camera_io_pkg::PERIOD_MIN) ?
            camera_io_pkg::PERIOD_MIN : wdata[23:0];
      end
      else if (wr && addr[7:6] == camera_io_pkg::ADDR_DUTY_BASE[7:6])
      begin
         // Whole byte is compared, so values of 128 and up clip instead of wrapping
         for (int j = 0; j < camera_io_pkg::NUM_LINES; j++)
            pwm_line_duty_percent[addr[5:2]][j*7 +: 7] <=
               (wdata[j*8 +: 8] > 8'(camera_io_pkg::PERCENT_MAX)) ?
               7'(camera_io_pkg::PERCENT_MAX) : wdata[j*8 +: 7];
      end
   end

   // ==========================================================
   // Register reads
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         rdata <= 32'h00000000;
      else if (rd)
      begin
         if (addr == camera_io_pkg::ADDR_CONTROL)
            rdata <= {30'h00000000, seq_state == camera_io_pkg::SEQ_RUN, deb_en};
         else if (addr == camera_io_pkg::ADDR_STATUS)
            rdata <= {24'h000000, trig_src, deb_level, sequence_interval_index, pwm_raw[1:0]};
         else if (addr == camera_io_pkg::ADDR_LOGIC_CFG)
            rdata <= {24'h000000, cfg};
         else if (addr == camera_io_pkg::ADDR_HOLD)
            rdata <= {8'h00, debounce_hold_count};
         else if (addr == camera_io_pkg::ADDR_PRESCALE)
            rdata <= {28'h0000000, prescale_div};
         else if (addr == camera_io_pkg::ADDR_SEQ_COUNT)
            rdata <= {28'h0000000, seq_last};
         else if (addr[7:6] == camera_io_pkg::ADDR_PERIOD_BASE[7:6])
            rdata <= {8'h00, pwm_period_count[addr[5:2]]};
         else if (addr[7:6] == camera_io_pkg::ADDR_DUTY_BASE[7:6])
            rdata <= {1'b0, pwm_line_duty_percent[addr[5:2]][27:21],
                      1'b0, pwm_line_duty_percent[addr[5:2]][20:14],
                      1'b0, pwm_line_duty_percent[addr[5:2]][13:7],
                      1'b0, pwm_line_duty_percent[addr[5:2]][6:0]};
         else
            rdata <= camera_io_pkg::BUS_UNMAPPED;
      end
      else
         rdata <= 32'h00000000;
   end

   // ==========================================================
   // Debouncer
   // Input is taken as synchronous; a raw asynchronous line needs its own synchroniser
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         deb_level <= 1'b0;
         hold_cnt <= 24'h000000;
      end
      else if (trigger_in[0] == deb_level)
         hold_cnt <= 24'h000000;
      else if (hold_cnt + 24'h000001 >= debounce_hold_count)
      begin
         deb_level <= trigger_in[0];
         hold_cnt <= 24'h000000;
      end
      else
         hold_cnt <= hold_cnt + 24'h000001;
   end

   assign src_d = deb_en ? deb_level : trigger_in[0];

   // ==========================================================
   // Two cascaded combiner stages
   assign stage_a = combine(cfg.op_a, src_d, trigger_in[1]);
   assign stage_b = combine(cfg.op_b, stage_a, trigger_in[2]);
   assign trig_src = (cfg.route_a == camera_io_pkg::ROUTE_TRIGGER) ? stage_a :
                     (cfg.route_a == camera_io_pkg::ROUTE_STAGE) ? stage_b : src_d;

   // ==========================================================
   // Prescaler
   assign trig_edge = trig_src & ~trig_prev;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         trig_prev <= 1'b0;
         pre_cnt <= 4'h0;
         trigger_out <= 1'b0;
      end
      else
      begin
         trig_prev <= trig_src;
         trigger_out <= 1'b0;
         if (trig_edge)
         begin
            // Setting n divides by n+1, so 4 bits reach 16
            if (pre_cnt >= prescale_div)
            begin
               pre_cnt <= 4'h0;
               trigger_out <= 1'b1;
            end
            else
               pre_cnt <= pre_cnt + 4'h1;
         end
      end
   end

   // ==========================================================
   // Sequencer
   assign seq_start = (trigger_out || (wr && addr == camera_io_pkg::ADDR_CONTROL
                       && wdata[camera_io_pkg::CTRL_SW_TRIG]));

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         seq_state <= camera_io_pkg::SEQ_IDLE;
         sequence_interval_index <= 4'h0;
      end
      else
      begin
         case (seq_state)
            camera_io_pkg::SEQ_IDLE:
               if (seq_start)
               begin
                  seq_state <= camera_io_pkg::SEQ_RUN;
                  sequence_interval_index <= 4'h0;
               end
            camera_io_pkg::SEQ_RUN:
               // One modulator period per interval, then the next interval
               if (period_end)
               begin
                  if (sequence_interval_index >= seq_last)
                     seq_state <= camera_io_pkg::SEQ_IDLE;
                  else
                     sequence_interval_index <= sequence_interval_index + 4'h1;
               end
            default: seq_state <= camera_io_pkg::SEQ_IDLE;
         endcase
      end
   end

   pwm_line_set u_pwm
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .restart(seq_start && seq_state == camera_io_pkg::SEQ_IDLE),
      .period_count(pwm_period_count[sequence_interval_index]),
      .duty_percent(pwm_line_duty_percent[sequence_interval_index]),
      .lines(pwm_raw),
      .period_end(period_end)
   );

   // ==========================================================
   // Open-drain outputs: enable high pulls the line low, so active high = drive
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pwm_line <= 4'h0;
         pwm_line_oe <= 4'h0;
         logic_out <= 1'b0;
         logic_out_oe <= 1'b0;
      end
      else
      begin
         pwm_line <= 4'h0;
         pwm_line_oe <= (seq_state == camera_io_pkg::SEQ_RUN) ? pwm_raw : 4'h0;
         logic_out <= 1'b0;
         logic_out_oe <= (cfg.route_a == camera_io_pkg::ROUTE_OUT) & stage_b;
      end
   end

   // ==========================================================
   // Checks
   property p_nand;
      @(posedge clk_sys) disable iff (reset)
      (cfg.op_a == camera_io_pkg::OP_NAND) |-> (stage_a == ~(src_d & trigger_in[1]));
   endproperty
   a_nand: assert property (p_nand) else $error("nand wrong");

   property p_nor_inv;
      @(posedge clk_sys) disable iff (reset)
      (cfg.op_a == camera_io_pkg::OP_NOR_INV && !src_d && !trigger_in[1]) |-> !stage_a;
   endproperty
   a_nor_inv: assert property (p_nor_inv) else $error("inverted nor wrong");

   property p_and;
      @(posedge clk_sys) disable iff (reset)
      (cfg.op_a == camera_io_pkg::OP_AND) |-> (stage_a == (src_d & trigger_in[1]));
   endproperty
   a_and: assert property (p_and) else $error("and wrong");

   property p_oe_idle;
      @(posedge clk_sys) disable iff (reset)
      (seq_state != camera_io_pkg::SEQ_RUN) |=> (pwm_line_oe == 4'h0);
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("line driven while idle");

   property p_deb_hold;
      @(posedge clk_sys) disable iff (reset)
      (trigger_in[0] == deb_level) |=> $stable(deb_level);
   endproperty
   a_deb_hold: assert property (p_deb_hold) else $error("debounce passed early");

   property p_pre_pulse;
      @(posedge clk_sys) disable iff (reset)
      trigger_out |=> !trigger_out;
   endproperty
   a_pre_pulse: assert property (p_pre_pulse) else $error("prescale pulse too long");

   sequence s_last_end;
      seq_state == camera_io_pkg::SEQ_RUN && period_end && sequence_interval_index >= seq_last;
   endsequence
   property p_seq_end;
      @(posedge clk_sys) disable iff (reset)
      s_last_end |=> seq_state == camera_io_pkg::SEQ_IDLE;
   endproperty
   a_seq_end: assert property (p_seq_end) else $error("sequencer overran");
endmodule
`default_nettype wire

// File: hdl/camera_io_pkg.sv
package camera_io_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_LINES = 4;
   localparam int NUM_INTERVALS = 16;
   localparam int PERIOD_W = 24;
   localparam int HOLD_W = 24;
   localparam int PERCENT_MAX = 100;
   localparam logic [23:0] PERIOD_MIN = 24'h000001;
   localparam int CLOCK_STEP_NS = 15;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LOGIC_CFG = 8'h08;
   localparam logic [7:0] ADDR_HOLD = 8'h0C;
   localparam logic [7:0] ADDR_PRESCALE = 8'h10;
   localparam logic [7:0] ADDR_SEQ_COUNT = 8'h14;
   localparam logic [7:0] ADDR_PERIOD_BASE = 8'h40;
   localparam logic [7:0] ADDR_DUTY_BASE = 8'h80;

   // Control field positions
   localparam int CTRL_DEB_EN = 0;
   localparam int CTRL_SEQ_RUN = 1;
   localparam int CTRL_SW_TRIG = 2;

   // Reset values
   localparam logic [23:0] PERIOD_RESET = 24'h000064;
   localparam logic [23:0] HOLD_RESET = 24'h010466;
   localparam logic [3:0] PRESCALE_RESET = 4'h0;
   localparam logic [31:0] BUS_UNMAPPED = 32'h00000000;

   // ==========================================================
   // Logic combiner operations
   typedef enum logic [2:0]
   {
      OP_AND = 3'b000,
      OP_NAND = 3'b001,
      OP_OR = 3'b010,
      OP_NOR = 3'b011,
      OP_NOR_INV = 3'b100
   } logic_op_t;

   typedef enum logic [1:0]
   {
      ROUTE_TRIGGER = 2'b00,
      ROUTE_STAGE = 2'b01,
      ROUTE_OUT = 2'b10
   } route_t;

   typedef struct packed
   {
      logic [2:0] op_a;
      logic [2:0] op_b;
      logic [1:0] route_a;
   } logic_cfg_t;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'b00,
      SEQ_RUN = 2'b01
   } seq_state_t;
endpackage

// File: hdl/pwm_line_set.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_line_set
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic restart,
   input wire logic [23:0] period_count,
   input wire logic [27:0] duty_percent,
   output logic [3:0] lines,
   output logic period_end
);
   logic [23:0] count;
   logic [31:0] on_cycles [0:3];

   // ==========================================================
   // Period counter
   // Fixed frequency; only the high time depends on the duty field
   always_ff @(posedge clk_sys)
   begin
      if (reset || restart || period_end)
         count <= 24'h000000;
      else
         count <= count + 24'h000001;
   end

   assign period_end = (count + 24'h000001 >= period_count);

   // ==========================================================
   // Line compare
   // Division by the percent maximum is done once per cycle per line;
   // area traded for never holding a stale result
   for (genvar i = 0; i < 4; i++)
   begin : g_line
      assign on_cycles[i] = (32'(period_count) * 32'(duty_percent[i*7 +: 7]))
         / 32'(camera_io_pkg::PERCENT_MAX);
      always_ff @(posedge clk_sys)
      begin
         if (reset)
            lines[i] <= 1'b0;
         else
            lines[i] <= (32'(count) < on_cycles[i]);
      end
   end
endmodule
`default_nettype wire

// File: verif/trigger_lines_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Trigger switches and LED loads on the far side of the pins
module trigger_lines_model
(
   input wire logic clk_sys,
   input wire logic clear_counts,
   input wire logic [2:0] level_req,
   input wire logic [3:0] pwm_line_oe,
   output logic [2:0] trigger_in,
   output logic [3:0][15:0] on_counts
);
   // Loads are pulled up, so a driven open-drain line reads low
   logic [3:0] led_level;
   assign led_level = ~pwm_line_oe;
   // Switches move only at a clock edge, like a synchronised source
   always_ff @(posedge clk_sys)
   begin
      trigger_in <= level_req;
   end
   // Lit time of each LED in clock cycles
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (clear_counts)
            on_counts[i] <= 16'h0000;
         else if (led_level[i] == 1'b0)
            on_counts[i] <= on_counts[i] + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// File: verif/tb_camera_io_pwm_trigger_logic.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module tb_camera_io_pwm_trigger_logic;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   logic [2:0] level_req;
   logic clear_counts;
   logic [2:0] trigger_in;
   logic trigger_out;
   logic [3:0] pwm_line;
   logic [3:0] pwm_line_oe;
   logic logic_out;
   logic logic_out_oe;
   logic [3:0][15:0] on_counts;
   logic [31:0] d;
   int n_errors = 0;
   int compares = 0;
   int n_trig = 0;
   int base;
   int on_exp[4] = '{10, 30, 0, 22};

   always #25 clk_sys = ~clk_sys;

   camera_io_pwm_trigger_logic camera_io_pwm_trigger_logic_i (.clk_sys(clk_sys), .reset(reset),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trigger_in(trigger_in),
      .trigger_out(trigger_out), .pwm_line(pwm_line), .pwm_line_oe(pwm_line_oe),
      .logic_out(logic_out), .logic_out_oe(logic_out_oe));

   trigger_lines_model trigger_lines_model_i (.clk_sys(clk_sys), .clear_counts(clear_counts),
      .level_req(level_req), .pwm_line_oe(pwm_line_oe), .trigger_in(trigger_in),
      .on_counts(on_counts));

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      v = rdata;
   endtask

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   function automatic logic comb(input logic [2:0] op, input logic a, input logic b);
      case (op)
         3'h0: comb = a & b;
         3'h1: comb = ~(a & b);
         3'h2: comb = a | b;
         3'h3: comb = ~(a | b);
         default: comb = a | b;
      endcase
   endfunction

   task automatic end_of_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Monitors
   always @(posedge clk_sys)
   begin
      if (!reset)
      begin
         if (trigger_out === 1'b1)
            n_trig++;
         check({27'h0, logic_out, pwm_line}, 32'h0);
      end
   end

   // Hang guard, well above the few hundred cycles the tests need
   initial
   begin
      #1000000;
      n_errors++;
      end_of_test();
   end

   // ==========================================================
   // Tests
   initial
   begin
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      level_req = 3'b000;
      clear_counts = 1'b1;
      wait_cycles(8);
      reset <= 1'b0;
      clear_counts <= 1'b0;
      bus_read(camera_io_pkg::ADDR_HOLD, d);
      check(d, 32'h00010466);
      bus_read(camera_io_pkg::ADDR_PERIOD_BASE, d);
      check(d, 32'h00000064);
      bus_read(camera_io_pkg::ADDR_PRESCALE, d);
      check(d, 32'h0);
      bus_read(8'hC0, d);
      check(d, 32'h0);
      // Two intervals; the second duty word clips 200 to 100 percent
      bus_write(camera_io_pkg::ADDR_PERIOD_BASE, 32'h0000000A);
      bus_write(8'h44, 32'h00000014);
      bus_write(camera_io_pkg::ADDR_DUTY_BASE, 32'h1E006432);
      bus_write(8'h84, 32'h6301C819);
      bus_write(camera_io_pkg::ADDR_SEQ_COUNT, 32'h1);
      bus_write(camera_io_pkg::ADDR_CONTROL, 32'h4);
      wait_cycles(80);
      for (int i = 0; i < 4; i++)
         check({16'h0, on_counts[i]}, on_exp[i]);
      bus_read(camera_io_pkg::ADDR_CONTROL, d);
      check({31'h0, d[1]}, 32'h0);
      // Prescaler on the raw source, divide by 3 and by 16
      bus_write(camera_io_pkg::ADDR_LOGIC_CFG, 32'h2);
      for (int k = 0; k < 2; k++)
      begin
         bus_write(camera_io_pkg::ADDR_PRESCALE, (k == 1) ? 32'hF : 32'h2);
         base = n_trig;
         repeat ((k == 1) ? 16 : 6)
         begin
            level_req <= 3'b001;
            wait_cycles(3);
            level_req <= 3'b000;
            wait_cycles(3);
         end
         wait_cycles(8);
         check(n_trig - base, (k == 1) ? 1 : 2);
      end
      // Every operation and input pair, stage B passes stage A to the out line
      for (int i = 0; i < 5; i++)
      begin
         bus_write(camera_io_pkg::ADDR_LOGIC_CFG, {24'h0, 3'(i), 3'h0, 2'h2});
         for (int ab = 0; ab < 4; ab++)
         begin
            level_req <= {1'b1, ab[1], ab[0]};
            wait_cycles(6);
            check({31'h0, logic_out_oe}, {31'h0, comb(3'(i), ab[0], ab[1])});
         end
      end
      // Trigger routing: stage A alone, then through an OR in stage B
      level_req <= 3'b100;
      for (int r = 0; r < 2; r++)
      begin
         bus_write(camera_io_pkg::ADDR_LOGIC_CFG, {24'h0, 3'h0, 3'h2, 2'(r)});
         bus_read(camera_io_pkg::ADDR_STATUS, d);
         check({31'h0, d[7]}, 32'(r));
      end
      // Debouncer with a short hold so the run stays brief
      level_req <= 3'b000;
      bus_write(camera_io_pkg::ADDR_LOGIC_CFG, 32'h2);
      bus_write(camera_io_pkg::ADDR_HOLD, 32'h5);
      bus_write(camera_io_pkg::ADDR_CONTROL, 32'h1);
      wait_cycles(10);
      bus_read(camera_io_pkg::ADDR_STATUS, d);
      check({31'h0, d[6]}, 32'h0);
      level_req <= 3'b001;
      wait_cycles(4);
      level_req <= 3'b000;
      wait_cycles(1);
      level_req <= 3'b001;
      wait_cycles(4);
      level_req <= 3'b000;
      wait_cycles(10);
      bus_read(camera_io_pkg::ADDR_STATUS, d);
      check({31'h0, d[6]}, 32'h0);
      // Raw line already high here; the trigger source must still follow the old level
      level_req <= 3'b001;
      bus_read(camera_io_pkg::ADDR_STATUS, d);
      check({30'h0, d[7:6]}, 32'h0);
      wait_cycles(10);
      bus_read(camera_io_pkg::ADDR_STATUS, d);
      check({30'h0, d[7:6]}, 32'h3);
      end_of_test();
   end
endmodule
`default_nettype wire
